// file: hdl/clt_pkg.sv
package clt_pkg;

	// ==========================================================
	// Clock and timing
	// ==========================================================
	localparam int CLK_HZ          = 50_000_000;
	localparam int LOAD_TIME_US    = 1000;
	localparam int LOAD_CYCLES     = LOAD_TIME_US * (CLK_HZ / 1_000_000);
	localparam int LOCK_TIME_US    = 110;
	localparam int LOCK_CYCLES     = LOCK_TIME_US * (CLK_HZ / 1_000_000);
	localparam int OSC_KHZ         = 48_000;

	// ==========================================================
	// Stored configuration layout
	// ==========================================================
	localparam int        SEG_WORDS    = 8;
	localparam int        SEG_MAX      = 14;
	localparam logic [2:0] NV_I2C_ADDR = 3'h0;
	localparam logic [2:0] NV_PMB_ADDR = 3'h1;
	localparam logic [2:0] NV_CTRL     = 3'h2;
	localparam logic [2:0] NV_FREQ     = 3'h3;
	localparam logic [2:0] NV_FILE_CNT = 3'h4;
	localparam logic [2:0] NV_LAST     = 3'h4;

	// Control word fields
	localparam int CTRL_OFS_EN  = 0;
	localparam int CTRL_LOCK    = 1;
	localparam int CTRL_EN_LSB  = 2;

	// Software enable modes, two bits per loop
	localparam logic [1:0] EN_PIN = 2'h0;
	localparam logic [1:0] EN_ON  = 2'h1;
	localparam logic [1:0] EN_OFF = 2'h2;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [6:0]  I2C_ADDR_RST = 7'h10;
	localparam logic [6:0]  PMB_ADDR_RST = 7'h40;
	localparam logic [10:0] FREQ_RST     = 11'h1f4;
	localparam logic [3:0]  FILE_CNT_RST = 4'h1;

	// ==========================================================
	// Frequency command limits in kHz
	// ==========================================================
	localparam logic [10:0] FREQ_MIN     = 11'h0c8;
	localparam logic [10:0] FREQ_MAX     = 11'h7d0;
	localparam logic [10:0] FREQ_FINE    = 11'h3e8;
	localparam logic [10:0] FREQ_A_FLOOR = 11'h190;

	// Loop indices
	localparam int LOOP_A = 0;
	localparam int LOOP_B = 1;
	localparam int LOOP_C = 2;
	localparam int LOOP_D = 3;

	typedef enum logic [1:0] {
		CLT_POR  = 2'b00,
		CLT_READ = 2'b01,
		CLT_WAIT = 2'b11,
		CLT_RUN  = 2'b10
	} clt_state_e;

endpackage : clt_pkg

// file: hdl/clt_timebase.sv
`timescale 1ns/1ps

module clt_timebase #(
	parameter int LOAD_CYC = clt_pkg::LOAD_CYCLES,
	parameter int LOCK_CYC = clt_pkg::LOCK_CYCLES
) (
	// Clocks and reset
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        sync_clk,
	// Power monitors and straps (asynchronous)
	input  wire logic        supply_ok,
	input  wire logic        core_rail_pin,
	input  wire logic        osc_stable,
	input  wire logic [3:0]  seg_strap,
	input  wire logic [3:0]  addr_strap_pin,
	// Stored configuration read port, data taken in the same cycle the address is presented
	output logic      [7:0]  nv_config_store_addr,
	input  wire logic [15:0] nv_config_store_data,
	// Register writes from the host command decoder
	input  wire logic [15:0] wr_data,
	input  wire logic        i2c_addr_wr,
	input  wire logic        pmbus_addr_wr,
	input  wire logic        ctrl_wr,
	input  wire logic        freq_wr,
	input  wire logic [1:0]  freq_loop,
	output logic             freq_ack,
	input  wire logic [1:0]  freq_rd_loop,
	output logic      [10:0] freq_rd_data,
	// Loop enable inputs (asynchronous)
	input  wire logic [3:0]  loop_en_pin,
	input  wire logic [3:0]  vin_ok,
	// Status and addresses
	output logic             por_active,
	output logic             load_done,
	output logic      [6:0]  i2c_addr,
	output logic      [6:0]  pmbus_addr,
	output logic             i2c_respond,
	output logic             pmbus_respond,
	output logic      [3:0]  file_count,
	// Loop timing
	output logic      [3:0]  loop_run,
	output logic      [3:0]  loop_phase_start,
	output logic      [11:0] period_active,
	output logic             sync_locked
);

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	logic [18:0] meta_q;
	logic [18:0] sync_q;
	logic [18:0] async_in;

	assign async_in = {vin_ok, loop_en_pin, addr_strap_pin, seg_strap,
		osc_stable, core_rail_pin, supply_ok};

	// Two flops for every pin input
	always_ff @(posedge clk) begin
		meta_q <= async_in;
		sync_q <= meta_q;
	end

	logic       por_ok;
	logic [3:0] seg_s;
	logic [3:0] ofs_s;
	logic [3:0] en_s;
	logic [3:0] vin_s;

	assign por_ok = &sync_q[2:0];
	assign seg_s  = sync_q[6:3];
	assign ofs_s  = sync_q[10:7];
	assign en_s   = sync_q[14:11];
	assign vin_s  = sync_q[18:15];

	// ==========================================================
	// Power-on reset and load sequence
	// ==========================================================
	clt_pkg::clt_state_e state;
	logic [16:0]         load_cnt;
	logic [2:0]          word_idx;
	logic                rd_pend;
	logic [2:0]          rd_idx;
	logic [3:0]          seg_sel;
	logic                addr_read;

	// Sequencer from reset through load to run
	always_ff @(posedge clk) begin
		if (reset) begin
			state    <= clt_pkg::CLT_POR;
			load_cnt <= 17'h0;
			word_idx <= 3'h0;
			seg_sel  <= 4'h0;
		end else begin
			unique case (state)
				clt_pkg::CLT_POR: begin
					load_cnt <= 17'h0;
					word_idx <= 3'h0;
					if (por_ok) begin
						state   <= clt_pkg::CLT_READ;
						seg_sel <= (seg_s > 4'(clt_pkg::SEG_MAX))
							? 4'(clt_pkg::SEG_MAX) : seg_s;
					end
				end
				clt_pkg::CLT_READ: begin
					load_cnt <= load_cnt + 17'h1;
					word_idx <= word_idx + 3'h1;
					if (word_idx == clt_pkg::NV_LAST)
						state <= clt_pkg::CLT_WAIT;
				end
				clt_pkg::CLT_WAIT: begin
					load_cnt <= load_cnt + 17'h1;
					if (load_cnt >= 17'(LOAD_CYC - 1))
						state <= clt_pkg::CLT_RUN;
				end
				clt_pkg::CLT_RUN: begin
					load_cnt <= load_cnt;
				end
			endcase
			if (!por_ok)
				state <= clt_pkg::CLT_POR;
		end
	end

	// Read address into the stored configuration
	always_ff @(posedge clk) begin
		if (reset) begin
			nv_config_store_addr <= 8'h0;
			rd_pend              <= 1'b0;
			rd_idx               <= 3'h0;
		end else begin
			nv_config_store_addr <= 8'(seg_sel * clt_pkg::SEG_WORDS)
				+ {5'h0, word_idx};
			rd_pend <= (state == clt_pkg::CLT_READ);
			rd_idx  <= word_idx;
		end
	end

	assign por_active = (state == clt_pkg::CLT_POR);

	// Load done and address-read flags
	always_ff @(posedge clk) begin
		if (reset) begin
			load_done <= 1'b0;
			addr_read <= 1'b0;
		end else begin
			load_done <= (state == clt_pkg::CLT_RUN);
			if (state == clt_pkg::CLT_POR)
				addr_read <= 1'b0;
			else if (rd_pend && rd_idx == clt_pkg::NV_PMB_ADDR)
				addr_read <= 1'b1;
		end
	end

	// ==========================================================
	// Working registers
	// ==========================================================
	logic [6:0]  base_i2c_addr;
	logic [6:0]  base_pmbus_addr;
	logic        ofs_en;
	logic        addr_lock;
	logic [7:0]  en_mode;
	logic [10:0] freq_set [4];
	logic        host_ok;
	logic        freq_valid;
	logic        ld_wr;

	assign host_ok = (state == clt_pkg::CLT_RUN);
	assign ld_wr   = rd_pend;
	assign freq_valid = (wr_data[10:0] >= clt_pkg::FREQ_MIN)
		&& (wr_data[10:0] <= clt_pkg::FREQ_MAX)
		&& ((wr_data[10:0] <= clt_pkg::FREQ_FINE) || !wr_data[0]);

	// Address registers, loaded then host-writable until locked
	always_ff @(posedge clk) begin
		if (reset) begin
			base_i2c_addr   <= clt_pkg::I2C_ADDR_RST;
			base_pmbus_addr <= clt_pkg::PMB_ADDR_RST;
		end else if (ld_wr) begin
			if (rd_idx == clt_pkg::NV_I2C_ADDR)
				base_i2c_addr <= nv_config_store_data[6:0];
			if (rd_idx == clt_pkg::NV_PMB_ADDR)
				base_pmbus_addr <= nv_config_store_data[6:0];
		end else if (host_ok && !addr_lock) begin
			if (i2c_addr_wr)
				base_i2c_addr <= wr_data[6:0];
			if (pmbus_addr_wr)
				base_pmbus_addr <= wr_data[6:0];
		end
	end

	// Control bits: offset enable, lock, software enables, file count
	always_ff @(posedge clk) begin
		if (reset) begin
			ofs_en     <= 1'b0;
			addr_lock  <= 1'b0;
			en_mode    <= 8'h0;
			file_count <= clt_pkg::FILE_CNT_RST;
		end else if (ld_wr) begin
			if (rd_idx == clt_pkg::NV_CTRL) begin
				ofs_en    <= nv_config_store_data[clt_pkg::CTRL_OFS_EN];
				addr_lock <= nv_config_store_data[clt_pkg::CTRL_LOCK];
				en_mode   <= nv_config_store_data[clt_pkg::CTRL_EN_LSB +: 8];
			end
			if (rd_idx == clt_pkg::NV_FILE_CNT)
				file_count <= nv_config_store_data[3:0];
		end else if (host_ok && ctrl_wr) begin
			if (!addr_lock) begin
				ofs_en    <= wr_data[clt_pkg::CTRL_OFS_EN];
				addr_lock <= wr_data[clt_pkg::CTRL_LOCK];
			end
			en_mode <= wr_data[clt_pkg::CTRL_EN_LSB +: 8];
		end
	end

	// Per-loop frequency settings as last written
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 4; i++)
				freq_set[i] <= clt_pkg::FREQ_RST;
		end else if (ld_wr && rd_idx == clt_pkg::NV_FREQ) begin
			for (int i = 0; i < 4; i++)
				freq_set[i] <= nv_config_store_data[10:0];
		end else if (host_ok && freq_wr && freq_valid) begin
			freq_set[freq_loop] <= wr_data[10:0];
		end
	end

	// Acknowledge and read-back
	always_ff @(posedge clk) begin
		if (reset) begin
			freq_ack     <= 1'b0;
			freq_rd_data <= clt_pkg::FREQ_RST;
		end else begin
			freq_ack     <= host_ok && freq_wr && freq_valid;
			freq_rd_data <= freq_set[freq_rd_loop];
		end
	end

	// ==========================================================
	// Effective addresses
	// ==========================================================
	always_ff @(posedge clk) begin
		if (reset) begin
			i2c_addr      <= clt_pkg::I2C_ADDR_RST;
			pmbus_addr    <= clt_pkg::PMB_ADDR_RST;
			i2c_respond   <= 1'b0;
			pmbus_respond <= 1'b0;
		end else begin
			i2c_addr   <= base_i2c_addr + (ofs_en ? {3'h0, ofs_s} : 7'h0);
			pmbus_addr <= base_pmbus_addr + (ofs_en ? {3'h0, ofs_s} : 7'h0);
			i2c_respond   <= host_ok && (base_i2c_addr != 7'h0);
			pmbus_respond <= host_ok && (base_pmbus_addr != 7'h0);
		end
	end

	// ==========================================================
	// Loop enables
	// ==========================================================
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_run
			logic [1:0] mode;
			assign mode = en_mode[2*g +: 2];
			always_ff @(posedge clk) begin
				if (reset)
					loop_run[g] <= 1'b0;
				else if (!host_ok || !addr_read || !vin_s[g])
					loop_run[g] <= 1'b0;
				else if (mode == clt_pkg::EN_ON)
					loop_run[g] <= 1'b1;
				else if (mode == clt_pkg::EN_OFF)
					loop_run[g] <= 1'b0;
				else
					loop_run[g] <= en_s[g];
			end
		end
	endgenerate

	// ==========================================================
	// Period divider: (2*48000 + f) / (2*f)
	// ==========================================================
	logic [16:0] div_rem;
	logic [16:0] div_num;
	logic [11:0] div_den;
	logic [11:0] div_quo;
	logic [4:0]  div_bit;
	logic        div_busy;
	logic [10:0] freq_c_q;
	logic [11:0] prog_per;
	logic [17:0] div_trial;

	assign div_trial = {div_rem, div_num[16]} - {6'h0, div_den};

	// Starts again once idle whenever the loop C setting differs from the last one divided
	always_ff @(posedge clk) begin
		if (reset) begin
			freq_c_q <= 11'h0;
			div_busy <= 1'b0;
			div_rem  <= 17'h0;
			div_num  <= 17'h0;
			div_den  <= 12'h0;
			div_quo  <= 12'h0;
			div_bit  <= 5'h0;
			prog_per <= 12'h0;
		end else if (!div_busy && freq_set[clt_pkg::LOOP_C] != freq_c_q) begin
			freq_c_q <= freq_set[clt_pkg::LOOP_C];
			div_busy <= 1'b1;
			div_rem  <= 17'h0;
			div_num  <= 17'(2 * clt_pkg::OSC_KHZ)
				+ {6'h0, freq_set[clt_pkg::LOOP_C]};
			div_den  <= {freq_set[clt_pkg::LOOP_C], 1'b0};
			div_quo  <= 12'h0;
			div_bit  <= 5'd17;
		end else if (div_busy) begin
			div_num <= {div_num[15:0], 1'b0};
			if (!div_trial[17]) begin
				div_rem <= div_trial[16:0];
				div_quo <= {div_quo[10:0], 1'b1};
			end else begin
				div_rem <= {div_rem[15:0], div_num[16]};
				div_quo <= {div_quo[10:0], 1'b0};
			end
			div_bit <= div_bit - 5'h1;
			if (div_bit == 5'h1) begin
				div_busy <= 1'b0;
				prog_per <= !div_trial[17] ? {div_quo[10:0], 1'b1}
					: {div_quo[10:0], 1'b0};
			end
		end
	end

	// ==========================================================
	// Sync clock domain: event toggle
	// ==========================================================
	logic rst_s1;
	logic rst_s2;
	logic sync_tog;

	// Reset brought into the sync domain
	always_ff @(posedge sync_clk) begin
		rst_s1 <= reset;
		rst_s2 <= rst_s1;
	end

	// One toggle per sync rising edge
	always_ff @(posedge sync_clk) begin
		if (rst_s2)
			sync_tog <= 1'b0;
		else
			sync_tog <= ~sync_tog;
	end

	// ==========================================================
	// Sync edge detection and period measurement
	// ==========================================================
	logic       tog_m;
	logic       tog_s;
	logic       tog_d;
	logic       sync_evt;
	logic [11:0] meas_cnt;
	logic [11:0] meas_per;
	logic        meas_ok;

	always_ff @(posedge clk) begin
		tog_m <= sync_tog;
		tog_s <= tog_m;
	end

	// Edge of the synchronised toggle
	always_ff @(posedge clk) begin
		if (reset)
			tog_d <= 1'b0;
		else
			tog_d <= tog_s;
	end

	assign sync_evt = tog_s ^ tog_d;

	// Clock cycles between sync edges, saturating when sync stops
	always_ff @(posedge clk) begin
		if (reset) begin
			meas_cnt <= 12'h0;
			meas_per <= 12'h0;
			meas_ok  <= 1'b0;
		end else if (sync_evt) begin
			meas_cnt <= 12'h1;
			meas_per <= meas_cnt;
			meas_ok  <= (meas_cnt != 12'hfff);
		end else if (meas_cnt != 12'hfff) begin
			meas_cnt <= meas_cnt + 12'h1;
		end else begin
			meas_ok <= 1'b0;
		end
	end

	// ==========================================================
	// Frequency lock loop
	// ==========================================================
	logic [11:0] diff;
	logic        in_lock_win;
	logic        out_unlock_win;
	logic [12:0] lock_cnt;

	assign diff = (meas_per > prog_per) ? meas_per - prog_per
		: prog_per - meas_per;
	assign in_lock_win = meas_ok
		&& ({diff, 4'h0} <= {4'h0, prog_per});
	assign out_unlock_win = !meas_ok
		|| ({1'b0, diff, 3'h0} > {4'h0, prog_per});

	// Lock qualification timer and lock state with hysteresis
	always_ff @(posedge clk) begin
		if (reset) begin
			lock_cnt    <= 13'h0;
			sync_locked <= 1'b0;
		end else if (sync_locked) begin
			lock_cnt <= 13'h0;
			if (out_unlock_win)
				sync_locked <= 1'b0;
		end else if (!in_lock_win) begin
			lock_cnt <= 13'h0;
		end else if (lock_cnt >= 13'(LOCK_CYC - 1)) begin
			sync_locked <= 1'b1;
		end else begin
			lock_cnt <= lock_cnt + 13'h1;
		end
	end

	// ==========================================================
	// Phase counter and loop phase starts
	// ==========================================================
	logic [11:0] cnt;
	logic        wrap;
	logic        a_half;
	logic        a_slow;
	logic        a_tick;

	assign wrap = (cnt >= period_active - 12'h1);
	assign a_slow = (freq_set[clt_pkg::LOOP_A] < freq_set[clt_pkg::LOOP_C])
		&& (freq_set[clt_pkg::LOOP_C] >= clt_pkg::FREQ_A_FLOOR);
	assign a_tick = !a_slow || a_half;

	// Active period: tracks sync when locked, else relaxes to programmed
	always_ff @(posedge clk) begin
		if (reset)
			period_active <= 12'h0;
		else if (period_active == 12'h0)
			period_active <= prog_per;
		else if (sync_locked && sync_evt)
			period_active <= meas_per;
		else if (!sync_locked && wrap) begin
			if (period_active < prog_per)
				period_active <= period_active + 12'h1;
			else if (period_active > prog_per)
				period_active <= period_active - 12'h1;
		end
	end

	// Shared counter; a locked sync edge realigns phase
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt    <= 12'h0;
			a_half <= 1'b0;
		end else if ((sync_locked && sync_evt) || wrap) begin
			cnt    <= 12'h0;
			a_half <= ~a_half;
		end else begin
			cnt <= cnt + 12'h1;
		end
	end

	// Quarter-period start pulses: C at 0, B at 1/4, D at 1/2, A at 3/4 (only every other period while a_slow)
	always_ff @(posedge clk) begin
		if (reset)
			loop_phase_start <= 4'h0;
		else begin
			loop_phase_start[clt_pkg::LOOP_C] <= (cnt == 12'h0);
			loop_phase_start[clt_pkg::LOOP_B] <=
				(cnt == {2'h0, period_active[11:2]});
			loop_phase_start[clt_pkg::LOOP_D] <=
				(cnt == {1'b0, period_active[11:1]});
			loop_phase_start[clt_pkg::LOOP_A] <= a_tick
				&& (cnt == {1'b0, period_active[11:1]}
				+ {2'h0, period_active[11:2]});
		end
	end

endmodule : clt_timebase

// file: dv/clt_timebase_properties.sv
`timescale 1ns/1ps

// ==========================================================
// Port checker of the timebase
// ==========================================================
module clt_timebase_properties #(
	parameter int LOAD_CYC = 50
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Inputs watched
	input wire logic        supply_ok,
	input wire logic [15:0] wr_data,
	input wire logic        ctrl_wr,
	input wire logic        freq_wr,
	// Outputs watched
	input wire logic        freq_ack,
	input wire logic        por_active,
	input wire logic        load_done,
	input wire logic [6:0]  i2c_addr,
	input wire logic [6:0]  pmbus_addr,
	input wire logic        i2c_respond,
	input wire logic        pmbus_respond,
	input wire logic [3:0]  loop_run,
	input wire logic [11:0] period_active,
	input wire logic        sync_locked
);
	int   load_cnt;
	logic lock_seen;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Accepted frequency command range and step
	function automatic logic fok(input logic [15:0] f);
		return f >= 16'h00c8 && f <= 16'h07d0 && (f <= 16'h03e8 || !f[0]);
	endfunction : fok

	// Cycles since the power-on state was left
	always_ff @(posedge clk) begin
		if (reset || por_active)
			load_cnt <= 0;
		else if (!load_done)
			load_cnt <= load_cnt + 1;
	end

	// Lock bit as the host wrote it
	always_ff @(posedge clk) begin
		if (reset || !load_done)
			lock_seen <= 1'b0;
		else if (ctrl_wr && wr_data[1])
			lock_seen <= 1'b1;
	end

	a_por_drop: assert property (!supply_ok [*5] |-> por_active)
		else $error("power-on state not held");
	a_por_no_load: assert property (
		por_active && $past(por_active) |-> !load_done)
		else $error("loaded during power-on state");
	a_load_time: assert property ($rose(load_done) |->
		load_cnt >= LOAD_CYC && load_cnt <= LOAD_CYC + 8)
		else $error("load time off");
	a_freq_ack_ok: assert property (
		freq_wr && load_done && fok(wr_data) |=> freq_ack)
		else $error("valid frequency not acked");
	a_freq_nack: assert property (freq_ack |-> $past(freq_wr) &&
		$past(load_done) && fok($past(wr_data)))
		else $error("ack without valid write");
	a_resp_load: assert property (
		i2c_respond || pmbus_respond |-> load_done)
		else $error("respond before load");
	a_run_load: assert property (loop_run != 4'h0 |-> load_done)
		else $error("loop runs before load");
	a_addr_lock: assert property (lock_seen && $past(lock_seen) |->
		$stable(i2c_addr) && $stable(pmbus_addr))
		else $error("address changed while locked");
	a_period_step: assert property ($past(load_done) &&
		!sync_locked && !$past(sync_locked) &&
		$past(period_active) != 12'h000 |->
		period_active <= $past(period_active) + 12'h001 &&
		period_active + 12'h001 >= $past(period_active))
		else $error("period jumped while unlocked");

	c_load: cover property ($rose(load_done));
	c_ack: cover property (freq_ack);
	c_lock: cover property (lock_seen);
	c_run: cover property (loop_run != 4'h0);
endmodule : clt_timebase_properties

bind clt_timebase clt_timebase_properties #(
	.LOAD_CYC(LOAD_CYC)
) clt_timebase_properties_inst (
	.clk(clk), .reset(reset), .supply_ok(supply_ok), .wr_data(wr_data),
	.ctrl_wr(ctrl_wr), .freq_wr(freq_wr), .freq_ack(freq_ack),
	.por_active(por_active), .load_done(load_done), .i2c_addr(i2c_addr),
	.pmbus_addr(pmbus_addr), .i2c_respond(i2c_respond),
	.pmbus_respond(pmbus_respond), .loop_run(loop_run),
	.period_active(period_active), .sync_locked(sync_locked)
);

// file: dv/clt_far_model.sv
`timescale 1ns/1ps

// ==========================================================
// Stored configuration and external sync source
// ==========================================================
module clt_far_model (
	// Stored configuration read port
	input wire logic [7:0]  nv_config_store_addr,
	output logic     [15:0] nv_config_store_data,
	// Sync source control
	input wire logic        sync_en,
	output logic            sync_clk
);
	// Segment words, answered while the registered address stands
	always_comb begin
		case (nv_config_store_addr[2:0])
			clt_pkg::NV_I2C_ADDR:
				nv_config_store_data = {12'h002, nv_config_store_addr[6:3]};
			clt_pkg::NV_PMB_ADDR:
				nv_config_store_data = {12'h003, nv_config_store_addr[6:3]};
			clt_pkg::NV_CTRL: nv_config_store_data = 16'h0000;
			clt_pkg::NV_FREQ: nv_config_store_data = 16'h01f4;
			clt_pkg::NV_FILE_CNT: nv_config_store_data = 16'h0003;
			default: nv_config_store_data = 16'hffff;
		endcase
	end

	// Sync runs while enabled and is parked low otherwise
	initial begin
		sync_clk = 1'b0;
		#13;
		forever begin
			sync_clk = sync_en ? ~sync_clk : 1'b0;
			#80;
		end
	end
endmodule : clt_far_model

// file: dv/clt_timebase_tb.sv
`timescale 1ns/1ps

// ==========================================================
// Timebase bench
// ==========================================================
module clt_timebase_tb;
	logic        clk, reset, sync_clk, sync_en, ack;
	logic        supply_ok, core_rail_pin, osc_stable;
	logic [3:0]  seg_strap, addr_strap_pin, loop_en_pin, vin_ok;
	logic [7:0]  nv_addr;
	logic [15:0] nv_data, wr_data;
	logic        i2c_addr_wr, pmbus_addr_wr, ctrl_wr, freq_wr, freq_ack;
	logic [1:0]  freq_loop, freq_rd_loop;
	logic [10:0] freq_rd_data;
	logic        por_active, load_done, i2c_respond, pmbus_respond;
	logic [6:0]  i2c_addr, pmbus_addr;
	logic [3:0]  file_count, loop_run, loop_phase_start;
	logic [11:0] period_active;
	logic        sync_locked;
	int          fails, samples_checked;

	clt_timebase #(.LOAD_CYC(50), .LOCK_CYC(20)) clt_timebase_inst (
		.clk(clk), .reset(reset), .sync_clk(sync_clk),
		.supply_ok(supply_ok), .core_rail_pin(core_rail_pin),
		.osc_stable(osc_stable), .seg_strap(seg_strap),
		.addr_strap_pin(addr_strap_pin), .nv_config_store_addr(nv_addr),
		.nv_config_store_data(nv_data), .wr_data(wr_data),
		.i2c_addr_wr(i2c_addr_wr), .pmbus_addr_wr(pmbus_addr_wr),
		.ctrl_wr(ctrl_wr), .freq_wr(freq_wr), .freq_loop(freq_loop),
		.freq_ack(freq_ack), .freq_rd_loop(freq_rd_loop),
		.freq_rd_data(freq_rd_data), .loop_en_pin(loop_en_pin),
		.vin_ok(vin_ok), .por_active(por_active), .load_done(load_done),
		.i2c_addr(i2c_addr), .pmbus_addr(pmbus_addr),
		.i2c_respond(i2c_respond), .pmbus_respond(pmbus_respond),
		.file_count(file_count), .loop_run(loop_run),
		.loop_phase_start(loop_phase_start),
		.period_active(period_active), .sync_locked(sync_locked)
	);

	clt_far_model clt_far_model_inst (
		.nv_config_store_addr(nv_addr),
		.nv_config_store_data(nv_data), .sync_en(sync_en),
		.sync_clk(sync_clk)
	);

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Comparison, counted
	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			fails++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk

	task automatic final_report();
		$display("checked %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// Bounded wait ran out
	task automatic lost(input string m);
		chk(1'b0, m);
		final_report();
	endtask : lost

	// One-cycle write strobe; ack is taken in the next cycle
	task automatic wr(input int k, input logic [15:0] d, input logic [1:0] l);
		wr_data = d;
		freq_loop = l;
		{freq_wr, ctrl_wr, pmbus_addr_wr, i2c_addr_wr} = 4'h1 << k;
		@(negedge clk);
		ack = freq_ack;
		{freq_wr, ctrl_wr, pmbus_addr_wr, i2c_addr_wr} = 4'h0;
		@(negedge clk);
	endtask : wr

	task automatic t_reset();
		chk(i2c_addr === 7'h10 && pmbus_addr === 7'h40, "addr rst");
		chk(por_active === 1'b1 && load_done === 1'b0, "por rst");
		chk(freq_rd_data === 11'h1f4 && file_count === 4'h1, "cfg rst");
	endtask : t_reset

	task automatic t_power();
		int n;
		supply_ok = 1'b1;
		core_rail_pin = 1'b1;
		cyc(8);
		chk(por_active === 1'b1 && load_done === 1'b0, "osc ignored");
		osc_stable = 1'b1;
		n = 0;
		while (load_done !== 1'b1) begin
			if (++n > 300) lost("load timeout");
			@(negedge clk);
		end
		chk(n >= 50, "load early");
		chk(i2c_addr === 7'h2e && pmbus_addr === 7'h3e, "segment");
		chk(file_count === 4'h3, "file count");
		cyc(2);
		chk(i2c_respond === 1'b1 && pmbus_respond === 1'b1, "respond");
	endtask : t_power

	task automatic t_addr();
		wr(0, 16'h0000, 2'h0);
		wr(1, 16'h0000, 2'h0);
		cyc(2);
		chk(i2c_respond === 1'b0 && pmbus_respond === 1'b0, "zero");
		wr(0, 16'h0012, 2'h0);
		wr(1, 16'h0041, 2'h0);
		wr(2, 16'h0001, 2'h0);
		cyc(1);
		chk(i2c_addr === 7'h17 && pmbus_addr === 7'h46, "offset");
		wr(2, 16'h0003, 2'h0);
		wr(0, 16'h0055, 2'h0);
		wr(1, 16'h0055, 2'h0);
		cyc(1);
		chk(i2c_addr === 7'h17 && pmbus_addr === 7'h46, "lock");
	endtask : t_addr

	task automatic t_freq();
		logic [15:0] bad [3] = '{16'h00c7, 16'h07d2, 16'h03e9};
		int n;
		foreach (bad[i]) begin
			wr(3, bad[i], 2'h2);
			chk(ack === 1'b0, "bad acked");
		end
		wr(3, 16'h03ea, 2'h1);
		chk(ack === 1'b1, "B no ack");
		wr(3, 16'h01c2, 2'h2);
		chk(ack === 1'b1, "C no ack");
		wr(3, 16'h012c, 2'h0);
		chk(ack === 1'b1, "A no ack");
		freq_rd_loop = 2'h0;
		cyc(2);
		chk(freq_rd_data === 11'h12c, "read A");
		n = 0;
		while (period_active !== 12'h06b) begin
			if (++n > 5000) lost("period timeout");
			@(negedge clk);
		end
		cyc(300);
		chk(period_active === 12'h06b, "period");
	endtask : t_freq

	task automatic t_phase(input int na_exp);
		int n, b, d, a, na;
		n = 0;
		while (loop_phase_start[2] !== 1'b1) begin
			if (++n > 300) lost("no C start");
			@(negedge clk);
		end
		b = -1;
		d = -1;
		a = -1;
		na = 0;
		for (int i = 1; i <= 214; i++) begin
			@(negedge clk);
			if (loop_phase_start[1] === 1'b1 && b < 0) b = i;
			if (loop_phase_start[3] === 1'b1 && d < 0) d = i;
			if (loop_phase_start[0] === 1'b1) begin
				na++;
				if (a < 0) a = i % 107;
			end
		end
		chk(b == 26 && d == 53, "B D phase");
		chk(a == 79 && na == na_exp, "A phase");
	endtask : t_phase

	task automatic t_run();
		loop_en_pin = 4'b0101;
		vin_ok = 4'b1110;
		wr(2, 16'h0093, 2'h0);
		cyc(6);
		chk(loop_run === 4'b0010, "run vin");
		vin_ok = 4'hf;
		cyc(6);
		chk(loop_run === 4'b0011, "run pin");
	endtask : t_run

	task automatic t_sync();
		sync_en = 1'b1;
		cyc(600);
		chk(sync_locked === 1'b0 && period_active === 12'h06b, "sync");
		sync_en = 1'b0;
	endtask : t_sync

	// Supply drop mid-run: back to power-on state, then a fresh load
	task automatic t_drop();
		int n;
		supply_ok = 1'b0;
		cyc(6);
		chk(por_active === 1'b1 && load_done === 1'b0, "drop");
		chk(loop_run === 4'h0 && i2c_respond === 1'b0, "drop run");
		supply_ok = 1'b1;
		n = 0;
		while (load_done !== 1'b1) begin
			if (++n > 300) lost("reload timeout");
			@(negedge clk);
		end
		chk(i2c_addr === 7'h2e && pmbus_addr === 7'h3e, "reload");
	endtask : t_drop

	// Main sequence
	initial begin
		fails = 0;
		samples_checked = 0;
		{reset, sync_en} = 2'b11;
		{supply_ok, core_rail_pin, osc_stable, ack} = 4'h0;
		seg_strap = 4'hf;
		addr_strap_pin = 4'h5;
		loop_en_pin = 4'h0;
		vin_ok = 4'h0;
		wr_data = 16'h0000;
		{freq_wr, ctrl_wr, pmbus_addr_wr, i2c_addr_wr} = 4'h0;
		freq_loop = 2'h0;
		freq_rd_loop = 2'h2;
		cyc(10);
		t_reset();
		reset = 1'b0;
		t_power();
		sync_en = 1'b0;
		t_addr();
		t_freq();
		t_phase(1);
		wr(3, 16'h01f4, 2'h0);
		t_phase(2);
		t_run();
		t_sync();
		t_drop();
		final_report();
	end
endmodule : clt_timebase_tb
